//--- pkg/usf_pkg.sv
// Operation
// - Status register is read-only; writes change nothing, flags clear only by sequences.
// - Transmit-empty flag sets at reset and when buffer moves into the shifter.
// - Status read with transmit-empty set, then data write, clears transmit-empty.
// - Transmit-complete sets at reset and when buffer empty with nothing being sent.
// - After status read, data write, enable rise or break write clears transmit-complete.
// - Receive-full flag sets when a character moves into the receive data register.
// - Status read with receive-full set, then data read, clears receive-full.
// - Idle flag sets after activity when line stays high 10 or 11 bit times.
// - Idle count selection clear: idle bit times count from right after start bit.
// - Idle count selection set: idle bit times count only after the stop bit.
// - After idle is cleared it stays clear until a new character sets receive-full.
// - New character while previous unread sets overrun and discards the new character.
// - Status read with overrun set, then data read, clears overrun.
// - Seven start samples, three per bit; any disagreement sets noise with receive-full.
// - Status read, then data read, clears the noise flag.
// - Zero sampled at stop bit sets framing error with receive-full; read sequence clears.
// - Parity enabled and mismatch sets parity error with receive-full; read sequence clears.
package usf_pkg;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] USF_OFF_STATUS = 8'h00;
  localparam logic [7:0] USF_OFF_DATA = 8'h04;
  localparam logic [7:0] USF_OFF_CTRL = 8'h08;
  localparam logic [7:0] USF_OFF_IRQ_STAT = 8'h0c;
  localparam logic [7:0] USF_OFF_IRQ_CLR = 8'h10;
  localparam logic [7:0] USF_OFF_IRQ_EN = 8'h14;
  localparam logic [1:0] USF_HRESP_OKAY = 2'h0;

  // ----------------------------------------
  // Field layouts
  // ----------------------------------------
  typedef struct packed {
    logic tx_buffer_empty_flag;
    logic tc;
    logic rx_buffer_full_flag;
    logic idle;
    logic ovr;
    logic nf;
    logic fe;
    logic pf;
  } usf_status_s;

  typedef struct packed {
    logic par_odd;
    logic par_en;
    logic long_char;
    logic idle_count_after_stop;
    logic break_queue_ctl;
    logic tx_enable_bit;
  } usf_ctrl_s;

  localparam int USF_CTRL_W = 6;
  localparam int USF_EV_W = 5;
  localparam usf_status_s USF_STATUS_RST = 8'hc0;
  localparam usf_status_s USF_RX_GROUP = 8'h3f;
  localparam usf_ctrl_s USF_CTRL_RST = 6'h00;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int USF_CLK_HZ = 20_000_000;
  localparam logic [3:0] USF_PH_LAST = 4'hf;
  localparam int USF_SAMPLES_PER_BIT = 16;
  localparam logic [3:0] USF_START_LO = 4'h4;
  localparam logic [3:0] USF_START_HI = 4'ha;
  localparam logic [3:0] USF_DATA_LO = 4'h7;
  localparam logic [3:0] USF_DATA_HI = 4'h9;
  localparam logic [3:0] USF_CHAR_SHORT = 4'ha;
  localparam logic [3:0] USF_CHAR_LONG = 4'hb;
  localparam logic [3:0] USF_BODY_SHORT = 4'h8;
  localparam logic [3:0] USF_BODY_LONG = 4'h9;

  typedef enum logic [1:0] {USF_R_IDLE, USF_R_START, USF_R_BITS} usf_rx_e;
  typedef enum logic {USF_T_IDLE, USF_T_SEND} usf_tx_e;

endpackage

//--- hw/usf_status_flags.sv
// The implementer's own choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
module usf_status_flags
  import usf_pkg::*;
#(
  parameter int BAUD = 125_000
) (
  // Clock, reset, enable
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Serial line
  input wire logic rx_i,
  output logic tx_o,
  // Interrupt
  output logic irq_o
);

  // ----------------------------------------
  // Derived timing
  // ----------------------------------------
  localparam int SAMPLE_DIV_I = USF_CLK_HZ / (BAUD * USF_SAMPLES_PER_BIT);
  localparam int SAMPLE_DIV = (SAMPLE_DIV_I < 1) ? 1 : SAMPLE_DIV_I;
  localparam logic [15:0] DIV_LAST = 16'(SAMPLE_DIV - 1);

  function automatic logic hit(input logic [31:0] a, input logic [7:0] off);
    hit = (a[7:0] == off);
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  usf_status_s flags, armed, next_flags, clr_mask, set_mask;
  usf_ctrl_s ctrl;
  usf_rx_e rx_state;
  usf_tx_e tx_state;
  logic rx_meta, rx_s;
  logic [15:0] div_cnt, tx_cnt;
  logic tick, bit_end, bit_val;
  logic [3:0] phase, bit_idx, idle_bits, tx_left, char_len;
  logic [2:0] ones;
  logic [8:0] rx_sr, rx_body, rx_data, tx_buf;
  logic [10:0] tx_sr;
  logic rx_done, rx_noise, rx_fe, rx_pbad, noise_acc;
  logic idle_armed, pre_pend, brk_pend;
  logic wr_pend;
  logic [31:0] wr_addr;
  logic addr_fire, st_rd_fire, data_rd_fire, data_wr_fire, ctrl_wr_fire, st_wr_fire;
  logic te_rise, brk_wr1, tc_kick;
  logic start_pre, start_brk, start_dat, tx_busy;
  logic rx_buffer_full_flag_set, ovr_set, idle_set, tc_set, pbit;
  logic [USF_EV_W-1:0] events, irq_stat, irq_en;
  logic [8:0] body9;
  logic [7:0] body8;
  logic [10:0] frame;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  // Reads act in the address phase, writes in the data phase once hwdata is valid
  assign addr_fire = clk_en_i && hsel_i && htrans_i[1] && hready_i;
  assign st_rd_fire = addr_fire && !hwrite_i && hit(haddr_i, USF_OFF_STATUS);
  assign data_rd_fire = addr_fire && !hwrite_i && hit(haddr_i, USF_OFF_DATA);
  assign data_wr_fire = clk_en_i && wr_pend && hit(wr_addr, USF_OFF_DATA);
  assign ctrl_wr_fire = clk_en_i && wr_pend && hit(wr_addr, USF_OFF_CTRL);
  assign st_wr_fire = clk_en_i && wr_pend && hit(wr_addr, USF_OFF_STATUS);
  assign te_rise = ctrl_wr_fire && hwdata_i[0] && !ctrl.tx_enable_bit;
  assign brk_wr1 = ctrl_wr_fire && hwdata_i[1];
  assign tc_kick = data_wr_fire || te_rise || brk_wr1;

  // Write data phase tracking; zero wait states so hreadyout never drops
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      wr_pend <= 1'b0;
      wr_addr <= 32'h0;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else if (clk_en_i) begin
      wr_pend <= addr_fire && hwrite_i;
      if (addr_fire) begin
        wr_addr <= haddr_i;
      end
      hreadyout_o <= 1'b1;
      hresp_o <= USF_HRESP_OKAY[0];
    end
  end

  // Read mux registered at the address phase; unmapped reads return zero
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      hrdata_o <= 32'h0;
    end else if (clk_en_i && addr_fire && !hwrite_i) begin
      if (hit(haddr_i, USF_OFF_STATUS)) begin
        hrdata_o <= {24'h0, flags};
      end else if (hit(haddr_i, USF_OFF_DATA)) begin
        hrdata_o <= {23'h0, rx_data};
      end else if (hit(haddr_i, USF_OFF_CTRL)) begin
        hrdata_o <= {26'h0, ctrl};
      end else if (hit(haddr_i, USF_OFF_IRQ_STAT)) begin
        hrdata_o <= {27'h0, irq_stat};
      end else if (hit(haddr_i, USF_OFF_IRQ_EN)) begin
        hrdata_o <= {27'h0, irq_en};
      end else begin
        hrdata_o <= 32'h0;
      end
    end
  end

  // Control register, transmit buffer and queued preamble/break requests
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ctrl <= USF_CTRL_RST;
      tx_buf <= 9'h0;
      pre_pend <= 1'b0;
      brk_pend <= 1'b0;
    end else if (clk_en_i) begin
      if (ctrl_wr_fire) begin
        ctrl <= hwdata_i[USF_CTRL_W-1:0];
      end
      if (data_wr_fire) begin
        tx_buf <= hwdata_i[8:0];
      end
      // A short 1-then-0 pulse on the break bit still queues one break
      if (te_rise) begin
        pre_pend <= 1'b1;
      end else if (start_pre) begin
        pre_pend <= 1'b0;
      end
      if (brk_wr1) begin
        brk_pend <= 1'b1;
      end else if (start_brk) begin
        brk_pend <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  assign char_len = ctrl.long_char ? USF_CHAR_LONG : USF_CHAR_SHORT;
  assign tick = (div_cnt == DIV_LAST);
  assign bit_end = tick && (phase == USF_PH_LAST);
  assign bit_val = (ones >= 3'h2);

  // Line synchroniser; only rx_s is looked at
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      rx_meta <= 1'b1;
      rx_s <= 1'b1;
      div_cnt <= 16'h0;
    end else if (clk_en_i) begin
      rx_meta <= rx_i;
      rx_s <= rx_meta;
      div_cnt <= tick ? 16'h0 : div_cnt + 16'h1;
    end
  end

  // Oversampling frame engine; phase also runs while idle to time idle bits
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      rx_state <= USF_R_IDLE;
      phase <= 4'h0;
      ones <= 3'h0;
      bit_idx <= 4'h0;
      rx_sr <= 9'h0;
      noise_acc <= 1'b0;
      rx_done <= 1'b0;
      rx_body <= 9'h0;
      rx_noise <= 1'b0;
      rx_fe <= 1'b0;
      rx_pbad <= 1'b0;
    end else if (clk_en_i) begin
      rx_done <= 1'b0;
      if (tick) begin
        phase <= phase + 4'h1;
        unique case (rx_state)
          USF_R_IDLE: begin
            if (!rx_s) begin
              rx_state <= USF_R_START;
              phase <= 4'h0;
              ones <= 3'h0;
              noise_acc <= 1'b0;
            end
          end
          USF_R_START: begin
            // Seven samples across the middle of the start bit
            if (phase >= USF_START_LO && phase <= USF_START_HI) begin
              ones <= ones + {2'h0, rx_s};
            end
            if (phase == USF_PH_LAST) begin
              ones <= 3'h0;
              bit_idx <= 4'h0;
              // A mostly-high start bit is a glitch, not a frame
              rx_state <= (ones > 3'h3) ? USF_R_IDLE : USF_R_BITS;
              noise_acc <= (ones != 3'h0);
            end
          end
          USF_R_BITS: begin
            if (phase >= USF_DATA_LO && phase <= USF_DATA_HI) begin
              ones <= ones + {2'h0, rx_s};
            end
            if (phase == USF_PH_LAST) begin
              ones <= 3'h0;
              noise_acc <= noise_acc || (ones != 3'h0 && ones != 3'h3);
              if (bit_idx < (ctrl.long_char ? USF_BODY_LONG : USF_BODY_SHORT)) begin
                rx_sr <= {bit_val, rx_sr[8:1]};
                bit_idx <= bit_idx + 4'h1;
              end else begin
                rx_state <= USF_R_IDLE;
                rx_done <= 1'b1;
                rx_body <= ctrl.long_char ? rx_sr : {1'b0, rx_sr[8:1]};
                rx_noise <= noise_acc || (ones != 3'h0 && ones != 3'h3);
                rx_fe <= !bit_val;
                rx_pbad <= ctrl.par_en && ((^rx_sr[8:1]) ^ (ctrl.long_char && rx_sr[0]) ^ ctrl.par_odd);
              end
            end
          end
          default: rx_state <= USF_R_IDLE;
        endcase
      end
    end
  end

  // Idle bit counter; selection decides whether frame bits may count
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      idle_bits <= 4'h0;
    end else if (clk_en_i && tick) begin
      if (rx_state == USF_R_IDLE && !rx_s) begin
        idle_bits <= 4'h0;
      end else if (bit_end) begin
        if (rx_state == USF_R_START) begin
          idle_bits <= 4'h0;
        end else if (rx_state == USF_R_BITS) begin
          idle_bits <= (bit_val && !ctrl.idle_count_after_stop) ? idle_bits + 4'h1 : 4'h0;
        end else if (idle_bits != 4'hf) begin
          idle_bits <= idle_bits + 4'h1;
        end
      end
    end
  end

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  assign tx_busy = (tx_state == USF_T_SEND);
  assign start_pre = !tx_busy && ctrl.tx_enable_bit && pre_pend;
  assign start_brk = !tx_busy && ctrl.tx_enable_bit && !pre_pend && (ctrl.break_queue_ctl || brk_pend);
  assign start_dat = !tx_busy && ctrl.tx_enable_bit && !pre_pend && !ctrl.break_queue_ctl && !brk_pend
                     && !flags.tx_buffer_empty_flag;
  assign pbit = (ctrl.long_char ? ^tx_buf[7:0] : ^tx_buf[6:0]) ^ ctrl.par_odd;
  assign body9 = ctrl.par_en ? {pbit, tx_buf[7:0]} : tx_buf;
  assign body8 = ctrl.par_en ? {pbit, tx_buf[6:0]} : tx_buf[7:0];
  assign frame = ctrl.long_char ? {1'b1, body9, 1'b0} : {2'b11, body8, 1'b0};

  // Shifter: preamble is a frame of ones, break a frame of zeros
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      tx_state <= USF_T_IDLE;
      tx_cnt <= 16'h0;
      tx_sr <= 11'h7ff;
      tx_left <= 4'h0;
      tx_o <= 1'b1;
    end else if (clk_en_i) begin
      tx_o <= tx_busy ? tx_sr[0] : 1'b1;
      unique case (tx_state)
        USF_T_IDLE: begin
          tx_cnt <= 16'h0;
          tx_left <= char_len;
          if (start_pre) begin
            tx_sr <= 11'h7ff;
            tx_state <= USF_T_SEND;
          end else if (start_brk) begin
            tx_sr <= 11'h000;
            tx_state <= USF_T_SEND;
          end else if (start_dat) begin
            tx_sr <= frame;
            tx_state <= USF_T_SEND;
          end
        end
        USF_T_SEND: begin
          tx_cnt <= tx_cnt + 16'h1;
          if (tx_cnt == 16'(SAMPLE_DIV * USF_SAMPLES_PER_BIT - 1)) begin
            tx_cnt <= 16'h0;
            tx_sr <= {1'b1, tx_sr[10:1]};
            tx_left <= tx_left - 4'h1;
            if (tx_left == 4'h1) begin
              tx_state <= USF_T_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  // A character arriving while a data read clears the old one in the same cycle is kept
  assign rx_buffer_full_flag_set = rx_done && !(flags.rx_buffer_full_flag && !clr_mask.rx_buffer_full_flag);
  assign ovr_set = rx_done && flags.rx_buffer_full_flag && !clr_mask.rx_buffer_full_flag;
  assign idle_set = idle_armed && (idle_bits >= char_len);
  // A kick starts new activity, so the idle condition is not re-asserted that cycle
  assign tc_set = flags.tx_buffer_empty_flag && !tx_busy && !pre_pend && !brk_pend && !ctrl.break_queue_ctl && !tc_kick;

  // Clears apply only to flags recorded at the last status read
  always_comb begin
    clr_mask = 8'h0;
    if (data_rd_fire) begin
      clr_mask = armed & USF_RX_GROUP;
    end
    clr_mask.tx_buffer_empty_flag = data_wr_fire && armed.tx_buffer_empty_flag;
    clr_mask.tc = tc_kick && armed.tc;
    set_mask = 8'h0;
    set_mask.tx_buffer_empty_flag = start_dat;
    set_mask.tc = tc_set;
    set_mask.rx_buffer_full_flag = rx_buffer_full_flag_set;
    set_mask.idle = idle_set;
    set_mask.ovr = ovr_set;
    set_mask.nf = rx_buffer_full_flag_set && rx_noise;
    set_mask.fe = rx_buffer_full_flag_set && rx_fe;
    set_mask.pf = rx_buffer_full_flag_set && rx_pbad;
    next_flags = (flags & ~clr_mask) | set_mask;
  end

  // Flags, receive data and the recorded mask; status writes are ignored
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      flags <= USF_STATUS_RST;
      armed <= 8'h0;
      rx_data <= 9'h0;
      idle_armed <= 1'b0;
    end else if (clk_en_i) begin
      flags <= next_flags;
      if (rx_buffer_full_flag_set) begin
        rx_data <= rx_body;
      end
      if (st_rd_fire) begin
        armed <= flags;
      end else begin
        armed <= armed & ~clr_mask;
      end
      if (rx_buffer_full_flag_set) begin
        idle_armed <= 1'b1;
      end else if (idle_set) begin
        idle_armed <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  assign events = {ovr_set, idle_set, rx_buffer_full_flag_set, tc_set && !flags.tc, start_dat};

  // Sticky status, write-one-to-clear; a new event wins over its clear
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      irq_stat <= 5'h0;
      irq_en <= 5'h0;
      irq_o <= 1'b0;
    end else if (clk_en_i) begin
      if (wr_pend && hit(wr_addr, USF_OFF_IRQ_CLR)) begin
        irq_stat <= (irq_stat & ~hwdata_i[USF_EV_W-1:0]) | events;
      end else begin
        irq_stat <= irq_stat | events;
      end
      if (wr_pend && hit(wr_addr, USF_OFF_IRQ_EN)) begin
        irq_en <= hwdata_i[USF_EV_W-1:0];
      end
      irq_o <= |(irq_stat & irq_en);
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence rx_clear_seq;
    (st_rd_fire && flags.rx_buffer_full_flag && !rx_done) ##3 (data_rd_fire && !rx_done);
  endsequence

  status_ro_a: assert property (st_wr_fire && !data_rd_fire && !tc_kick |=> (($past(flags) & ~flags) == 8'h0))
    else $error("status write cleared a flag");
  tx_buffer_empty_flag_load_a: assert property (start_dat && clk_en_i |=> flags.tx_buffer_empty_flag && tx_busy)
    else $error("buffer moved to shifter without empty flag");
  tx_buffer_empty_flag_clear_a: assert property ($fell(flags.tx_buffer_empty_flag) |-> $past(data_wr_fire) && $past(armed.tx_buffer_empty_flag))
    else $error("transmit-empty fell without armed data write");
  tc_set_a: assert property (clk_en_i && tc_set |=> flags.tc)
    else $error("transmit-complete not set while quiet");
  tc_clear_a: assert property ($fell(flags.tc) |-> $past(tc_kick) && $past(armed.tc))
    else $error("transmit-complete fell without qualifying access");
  rx_buffer_full_flag_seq_a: assert property (rx_clear_seq |=> !flags.rx_buffer_full_flag)
    else $error("status read then data read left receive-full set");
  idle_once_a: assert property ($rose(flags.idle) |-> $past(idle_armed) && !idle_armed)
    else $error("idle set without a new character");
  overrun_a: assert property (rx_done && clk_en_i && flags.rx_buffer_full_flag && !data_rd_fire |=> flags.ovr && $stable(rx_data))
    else $error("overrun not flagged or data overwritten");
  ovr_clear_a: assert property ($fell(flags.ovr) |-> $past(data_rd_fire))
    else $error("overrun cleared without data read");
  noise_pair_a: assert property ($rose(flags.nf) |-> $rose(flags.rx_buffer_full_flag))
    else $error("noise set apart from receive-full");
  noise_clear_a: assert property ($fell(flags.nf) |-> $past(data_rd_fire))
    else $error("noise cleared without data read");
  frame_pair_a: assert property ($rose(flags.fe) |-> $rose(flags.rx_buffer_full_flag))
    else $error("framing error set apart from receive-full");
  armed_only_a: assert property ($fell(flags.rx_buffer_full_flag) |-> $past(armed.rx_buffer_full_flag))
    else $error("receive-full cleared without recorded status read");

endmodule

//--- dv/usf_line_partner.sv
`timescale 1ns/1ps
module usf_line_partner #(
  parameter int BIT_CLKS = 16
) (
  input wire logic clk_i,
  input wire logic tx_i,
  output logic rx_o
);
  logic [7:0] got;
  int n_got;

  // Line idles high so the receiver never sees a false start
  initial begin
    rx_o = 1'b1;
    got = 8'h00;
    n_got = 0;
  end

  // Frame LSB first, each bit held whole so every sample agrees; stop level selectable
  task automatic send(input logic [7:0] b, input logic stop);
    rx_o <= 1'b0;
    repeat (BIT_CLKS) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      rx_o <= b[i];
      repeat (BIT_CLKS) @(posedge clk_i);
    end
    rx_o <= stop;
    repeat (BIT_CLKS) @(posedge clk_i);
    rx_o <= 1'b1;
  endtask

  // Clean frame except one inverted clock in the middle of the first data bit
  task automatic send_noisy(input logic [7:0] b);
    rx_o <= 1'b0;
    repeat (BIT_CLKS) @(posedge clk_i);
    rx_o <= b[0];
    repeat (BIT_CLKS / 2) @(posedge clk_i);
    rx_o <= ~b[0];
    @(posedge clk_i);
    rx_o <= b[0];
    repeat (BIT_CLKS / 2 - 1) @(posedge clk_i);
    for (int i = 1; i < 8; i++) begin
      rx_o <= b[i];
      repeat (BIT_CLKS) @(posedge clk_i);
    end
    rx_o <= 1'b1;
    repeat (BIT_CLKS) @(posedge clk_i);
  endtask

  // Capture characters sent by the block, sampled at mid-bit
  always begin
    @(negedge tx_i);
    repeat (BIT_CLKS / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CLKS) @(posedge clk_i);
      got[i] = tx_i;
    end
    repeat (BIT_CLKS) @(posedge clk_i);
    n_got++;
  end
endmodule

//--- dv/usf_status_flags_test.sv
`timescale 1ns/1ps
module usf_status_flags_test;
  import usf_pkg::*;
  localparam int BIT = 16;
  logic sys_clk_i;
  logic sys_rst_i;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic rx;
  logic tx;
  logic irq;
  int n_fail;
  int checked;

  // Fast baud keeps a bit at 16 clocks
  usf_status_flags #(.BAUD(1_250_000)) dut (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(1'b1),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .rx_i(rx), .tx_o(tx), .irq_o(irq)
  );

  usf_line_partner #(.BIT_CLKS(BIT)) partner (.clk_i(sys_clk_i), .tx_i(tx), .rx_o(rx));

  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One single AHB-Lite transfer; only the watchdog ends a wait for hready
  task automatic acc(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge sys_clk_i);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge sys_clk_i);
    while (hready !== 1'b1) @(posedge sys_clk_i);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge sys_clk_i);
    while (hready !== 1'b1) @(posedge sys_clk_i);
    rd = hrdata;
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    acc(a, 1'b1, d, x);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m, input string nm);
    logic [31:0] x;
    acc(a, 1'b0, 32'h0, x);
    chk(nm, x & m, exp);
  endtask

  task automatic bits(input int n);
    repeat (n * BIT) @(posedge sys_clk_i);
  endtask

  task automatic final_report();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Hang guard, far beyond the few thousand cycles the tests need
  initial begin
    repeat (40000) @(posedge sys_clk_i);
    n_fail++;
    final_report();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    n_fail = 0;
    checked = 0;
    sys_rst_i = 1'b1;
    repeat (20) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    rd(USF_OFF_STATUS, 32'hc0, 32'hff, "status reset");
    rd(USF_OFF_CTRL, 32'h0, 32'h3f, "ctrl reset");
    rd(8'h40, 32'h0, 32'hffffffff, "unmapped");
    wr(USF_OFF_STATUS, 32'h0);
    rd(USF_OFF_STATUS, 32'hc0, 32'hff, "status write");
    // Transmit two characters back to back
    wr(USF_OFF_CTRL, 32'h1);
    bits(12);
    rd(USF_OFF_STATUS, 32'hc0, 32'hff, "before tx");
    wr(USF_OFF_DATA, 32'h5a);
    rd(USF_OFF_STATUS, 32'h80, 32'hc0, "tx moved");
    wr(USF_OFF_DATA, 32'hc3);
    rd(USF_OFF_STATUS, 32'h0, 32'hc0, "tx queued");
    // First frame is captured after about 150 clocks, before the second overwrites it
    bits(9);
    chk("tx first", {24'h0, partner.got}, 32'h5a);
    bits(22);
    chk("tx second", {24'h0, partner.got}, 32'hc3);
    chk("tx count", partner.n_got, 32'h2);
    rd(USF_OFF_STATUS, 32'hc0, 32'hc0, "tx done");
    // Receive with interrupt, then idle behaviour
    wr(USF_OFF_IRQ_EN, 32'h04);
    partner.send(8'ha5, 1'b1);
    // Flag lands a few clocks after the stop bit, the interrupt one later
    bits(1);
    chk("irq set", {31'h0, irq}, 32'h1);
    rd(USF_OFF_IRQ_STAT, 32'h04, 32'h04, "irq stat");
    rd(USF_OFF_STATUS, 32'h20, 32'h3f, "rx full");
    rd(USF_OFF_DATA, 32'ha5, 32'hff, "rx char");
    rd(USF_OFF_STATUS, 32'h0, 32'h20, "rx clear");
    wr(USF_OFF_IRQ_CLR, 32'h1f);
    repeat (3) @(posedge sys_clk_i);
    chk("irq clear", {31'h0, irq}, 32'h0);
    bits(12);
    rd(USF_OFF_STATUS, 32'h10, 32'h10, "idle set");
    rd(USF_OFF_DATA, 32'ha5, 32'hff, "idle data");
    bits(12);
    rd(USF_OFF_STATUS, 32'h0, 32'h10, "idle once");
    // Idle start point per count selection, all-ones character
    for (int k = 0; k < 2; k++) begin
      wr(USF_OFF_CTRL, {29'h0, k[0], 2'h1});
      partner.send(8'hff, 1'b1);
      bits(5);
      rd(USF_OFF_STATUS, {26'h0, 1'b1, ~k[0], 4'h0}, 32'h30, "idle early");
      rd(USF_OFF_DATA, 32'hff, 32'hff, "ones data");
    end
    bits(8);
    rd(USF_OFF_STATUS, 32'h10, 32'h30, "idle late");
    rd(USF_OFF_DATA, 32'hff, 32'hff, "idle clear");
    // Overrun drops the second character and its framing error
    partner.send(8'h11, 1'b1);
    partner.send(8'h22, 1'b0);
    bits(1);
    rd(USF_OFF_STATUS, 32'h28, 32'h2f, "overrun");
    rd(USF_OFF_DATA, 32'h11, 32'hff, "kept char");
    rd(USF_OFF_STATUS, 32'h0, 32'h2f, "overrun clear");
    partner.send(8'h33, 1'b0);
    bits(2);
    rd(USF_OFF_STATUS, 32'h22, 32'h2f, "framing");
    rd(USF_OFF_DATA, 32'h33, 32'hff, "framing data");
    rd(USF_OFF_STATUS, 32'h0, 32'h2f, "framing clear");
    // One odd sample inside a data bit flags noise but keeps the bit
    partner.send_noisy(8'h66);
    bits(2);
    rd(USF_OFF_STATUS, 32'h24, 32'h2f, "noise");
    rd(USF_OFF_DATA, 32'h66, 32'hff, "noise data");
    rd(USF_OFF_STATUS, 32'h0, 32'h2f, "noise clear");
    // Even parity over the body; a single one is a mismatch
    wr(USF_OFF_CTRL, 32'h11);
    partner.send(8'h01, 1'b1);
    bits(2);
    rd(USF_OFF_STATUS, 32'h21, 32'h2f, "parity");
    rd(USF_OFF_DATA, 32'h01, 32'hff, "parity data");
    rd(USF_OFF_STATUS, 32'h0, 32'h2f, "parity clear");
    // A flag set after the status read survives the data read
    partner.send(8'h44, 1'b1);
    bits(1);
    rd(USF_OFF_DATA, 32'h44, 32'hff, "late char");
    rd(USF_OFF_STATUS, 32'h20, 32'h20, "not recorded");
    final_report();
  end
endmodule
